// >>> src/fscm_pkg.sv
package fscm_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int FRAME_TIME_NS = 136000;
   localparam int FRAME_CYC = FRAME_TIME_NS / CLK_PERIOD_NS;
   localparam int WIN_WIDE_CYC = 64;
   localparam int WIN_NARROW_CYC = 16;

   // ------------------------------------------------------------
   // code parameters
   // ------------------------------------------------------------
   localparam int C1_INFO_BYTES = 28;
   localparam int C1_PARITY_BYTES = 4;
   localparam int C2_INFO_BYTES = 24;
   localparam int C2_PARITY_BYTES = 4;
   localparam int RS_MIN_DIST = 5;
   localparam logic [2:0] C1_MAX_FIX = 3'((RS_MIN_DIST - 1) / 2);
   localparam logic [2:0] C2_MAX_FIX = 3'(RS_MIN_DIST - 1);

   // ------------------------------------------------------------
   // register map and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam int CTRL_WINDOW_WIDTH_SELECT_BIT = 0;
   localparam int CTRL_INTERP_BIT = 1;
   localparam int CTRL_FWD_LSB = 4;
   localparam int CTRL_BWD_LSB = 8;
   localparam logic [3:0] FWD_RESET = 4'hC;
   localparam logic [3:0] BWD_RESET = 4'h3;
   localparam int IRQ_LOCK_LOST = 0;
   localparam int IRQ_RESYNC = 1;
   localparam int IRQ_C2_FAIL = 2;

   // ------------------------------------------------------------
   // monitor codes
   // ------------------------------------------------------------
   localparam logic [3:0] MON_C1_FAIL = 4'h7;
   localparam logic [3:0] MON_C2_FAIL_COPY = 4'hE;
   localparam logic [3:0] MON_C2_FAIL_SET = 4'hF;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_SEARCH = 3'b001,
      ST_CONFIRM = 3'b010,
      ST_LOCK = 3'b100
   } fscm_state_e;

   typedef struct packed {
      logic done;
      logic [2:0] err_cnt;
      logic uncorr;
      logic efm_bad;
      logic player_bad;
   } fscm_c1_res_s;

   typedef struct packed {
      logic done;
      logic [2:0] err_cnt;
      logic uncorr;
      logic copy_c1;
   } fscm_c2_res_s;

   typedef struct packed {
      logic vld;
      logic [15:0] data;
      logic c2_ptr;
   } fscm_sample_s;

   typedef struct packed {
      fscm_state_e st;
      logic [12:0] tmr;
      logic [3:0] miss;
      logic frame_sync;
      logic frame_err;
      logic locked;
      logic window_width_select;
      logic interp;
      logic [3:0] fwd;
      logic [3:0] bwd;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic [3:0] monitor;
      logic c1_ptr;
      fscm_sample_s stg;
      logic [15:0] out_data;
      logic out_vld;
      logic out_c2_ptr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fscm_state_s;

endpackage

// >>> src/fscm_top.sv
// Summary of operation
// - a frame sync mark is expected every 136 us and anchors each frame
// - a frame without a recognised sync is flagged as error data
// - in confirm and lock, sync is window protected, width chosen by window_width_select
// - after lock, up to forward_protection_count missing syncs are inserted
// - one more missing sync than that opens the window to resynchronise
// - after resync, backward_protection_count misses reopen the window at once
// - both protection counts are 4-bit programmable, reset 12 and 3
// - c1 words 28+4 bytes, c2 words 24+4 bytes, distance 5
// - up to two c1 and four c2 symbol errors are correctable
// - c1 pointer follows c1 status, channel status and player status
// - c2-flagged samples are held or averaged from neighbours
// - c1 results map to monitor codes 0000-0001 and 0100-0111
// - c2 results map to monitor codes 1000-1100, 1110, 1111
module fscm_top #(
   parameter int FRAME_CYC = fscm_pkg::FRAME_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_det,
   input wire fscm_pkg::fscm_c1_res_s c1_res,
   input wire fscm_pkg::fscm_c2_res_s c2_res,
   input wire fscm_pkg::fscm_sample_s smp_in,
   output logic frame_sync,
   output logic frame_err,
   output logic sync_locked,
   output logic c1_ptr,
   output logic [3:0] correction_monitor,
   output logic out_vld,
   output logic [15:0] out_data,
   output logic out_c2_ptr,
   output logic irq
);
   import fscm_pkg::*;

   fscm_state_s r;
   fscm_state_s nxt_r;
   logic [12:0] win_lo;
   logic [12:0] win_hi;
   logic [12:0] win;
   logic in_win;
   logic frame_end;
   logic apb_done;
   logic c1_unc;
   logic c1_p;
   logic c2_unc;
   logic [16:0] avg_sum;
   logic [2:0] ev;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_r = r;
      ev = 3'h0;
      win = r.window_width_select ? 13'(WIN_NARROW_CYC) : 13'(WIN_WIDE_CYC);
      win_lo = 13'(FRAME_CYC) - win;
      win_hi = 13'(FRAME_CYC) + win;
      in_win = (r.tmr >= win_lo) && (r.tmr <= win_hi);
      frame_end = (r.tmr == win_hi);
      nxt_r.frame_sync = 1'b0;
      nxt_r.frame_err = 1'b0;
      nxt_r.out_vld = 1'b0;
      nxt_r.tmr = r.tmr + 13'h0001;

      // frame sync protection
      case (r.st)
         ST_SEARCH:
         begin
            if (sync_det)
            begin
               nxt_r.st = ST_CONFIRM;
               nxt_r.tmr = 13'h0000;
               nxt_r.miss = 4'h0;
               nxt_r.frame_sync = 1'b1;
               ev[IRQ_RESYNC] = 1'b1;
            end
            else if (r.tmr == 13'(FRAME_CYC - 1))
            begin
               nxt_r.tmr = 13'h0000;
               nxt_r.frame_err = 1'b1;
            end
         end
         ST_CONFIRM, ST_LOCK:
         begin
            if (sync_det && in_win)
            begin
               nxt_r.st = ST_LOCK;
               nxt_r.tmr = 13'h0000;
               nxt_r.miss = 4'h0;
               nxt_r.frame_sync = 1'b1;
            end
            else if (frame_end)
            begin
               nxt_r.frame_err = 1'b1;
               nxt_r.miss = r.miss + 4'h1;
               // realign so the next nominal mark is one frame after the missed one
               nxt_r.tmr = win;
               if (r.st == ST_LOCK && r.miss >= r.fwd)
               begin
                  nxt_r.st = ST_SEARCH;
                  nxt_r.tmr = 13'h0000;
                  ev[IRQ_LOCK_LOST] = 1'b1;
               end
               else if (r.st == ST_CONFIRM && (r.miss + 4'h1) >= r.bwd)
               begin
                  nxt_r.st = ST_SEARCH;
                  nxt_r.tmr = 13'h0000;
               end
               else
               begin
                  nxt_r.frame_sync = 1'b1;
               end
            end
         end
         default:
         begin
            nxt_r.st = ST_SEARCH;
            nxt_r.tmr = 13'h0000;
         end
      endcase
      nxt_r.locked = (nxt_r.st == ST_LOCK);

      // correction status and monitor; a c2 pass in the same cycle lands last
      c1_unc = c1_res.uncorr || (c1_res.err_cnt > C1_MAX_FIX);
      c1_p = c1_unc || (c1_res.err_cnt == C1_MAX_FIX) || c1_res.efm_bad
         || c1_res.player_bad || r.frame_err;
      c2_unc = c2_res.uncorr || (c2_res.err_cnt > C2_MAX_FIX);
      if (c1_res.done)
      begin
         nxt_r.c1_ptr = c1_p;
         nxt_r.monitor = c1_unc ? MON_C1_FAIL : {1'b0, c1_p, c1_res.err_cnt[1:0]};
      end
      if (c2_res.done)
      begin
         if (c2_unc)
         begin
            nxt_r.monitor = c2_res.copy_c1 ? MON_C2_FAIL_COPY : MON_C2_FAIL_SET;
            ev[IRQ_C2_FAIL] = 1'b1;
         end
         else
         begin
            nxt_r.monitor = {1'b1, c2_res.err_cnt};
         end
      end

      // concealment: one sample of latency so the following neighbour is known
      avg_sum = {r.out_data[15], r.out_data} + {smp_in.data[15], smp_in.data};
      if (smp_in.vld)
      begin
         nxt_r.stg = smp_in;
         if (r.stg.vld)
         begin
            nxt_r.out_vld = 1'b1;
            nxt_r.out_c2_ptr = r.stg.c2_ptr;
            if (!r.stg.c2_ptr)
               nxt_r.out_data = r.stg.data;
            else if (r.interp && !smp_in.c2_ptr)
               nxt_r.out_data = avg_sum[16:1];
            else
               nxt_r.out_data = r.out_data;
         end
      end

      // apb slave, one wait state
      apb_done = psel && penable && r.pready;
      nxt_r.pready = psel && penable && !r.pready;
      if (psel && penable && !r.pready)
      begin
         nxt_r.pslverr = !(paddr == OFS_CTRL || paddr == OFS_STATUS
            || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK);
         case (paddr)
            OFS_CTRL:
               nxt_r.prdata = {20'h0_0000, r.bwd, r.fwd, 2'b00, r.interp, r.window_width_select};
            OFS_STATUS:
               nxt_r.prdata = {20'h0_0000, r.monitor, r.miss, r.locked, r.st};
            OFS_IRQ_STAT:
               nxt_r.prdata = {29'h0000_0000, r.irq_stat};
            OFS_IRQ_MASK:
               nxt_r.prdata = {29'h0000_0000, r.irq_mask};
            default:
               nxt_r.prdata = 32'h0000_0000;
         endcase
      end
      else if (apb_done)
      begin
         nxt_r.pslverr = 1'b0;
         nxt_r.prdata = 32'h0000_0000;
      end
      if (apb_done && pwrite)
      begin
         if (paddr == OFS_CTRL)
         begin
            nxt_r.window_width_select = pwdata[CTRL_WINDOW_WIDTH_SELECT_BIT];
            nxt_r.interp = pwdata[CTRL_INTERP_BIT];
            nxt_r.fwd = pwdata[CTRL_FWD_LSB +: 4];
            nxt_r.bwd = pwdata[CTRL_BWD_LSB +: 4];
         end
         if (paddr == OFS_IRQ_MASK)
            nxt_r.irq_mask = pwdata[2:0];
      end
      // read clears, but an event in the same cycle survives
      if (apb_done && !pwrite && paddr == OFS_IRQ_STAT)
         nxt_r.irq_stat = ev;
      else
         nxt_r.irq_stat = r.irq_stat | ev;
      nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.st <= ST_SEARCH;
         r.fwd <= FWD_RESET;
         r.bwd <= BWD_RESET;
      end
      else
      begin
         r <= nxt_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign frame_sync = r.frame_sync;
   assign frame_err = r.frame_err;
   assign sync_locked = r.locked;
   assign c1_ptr = r.c1_ptr;
   assign correction_monitor = r.monitor;
   assign out_vld = r.out_vld;
   assign out_data = r.out_data;
   assign out_c2_ptr = r.out_c2_ptr;
   assign irq = r.irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_search_catch;
      @(posedge pclk) disable iff (!presetn)
      (r.st == ST_SEARCH && sync_det) |=> (frame_sync && r.tmr == 13'h0000 && r.st == ST_CONFIRM);
   endproperty
   a_search_catch: assert property (p_search_catch) else $error("sync not taken in search");

   property p_miss_err;
      @(posedge pclk) disable iff (!presetn)
      (r.st != ST_SEARCH && frame_end && !sync_det) |=> frame_err;
   endproperty
   a_miss_err: assert property (p_miss_err) else $error("missed frame not flagged");

   property p_out_window;
      @(posedge pclk) disable iff (!presetn)
      (r.st != ST_SEARCH && sync_det && r.tmr < win_lo && !frame_end) |=> !frame_sync;
   endproperty
   a_out_window: assert property (p_out_window) else $error("sync accepted outside window");

   property p_insert;
      @(posedge pclk) disable iff (!presetn)
      (r.st == ST_LOCK && frame_end && !sync_det && r.miss < r.fwd)
         |=> (frame_sync && r.st == ST_LOCK && r.tmr == win);
   endproperty
   a_insert: assert property (p_insert) else $error("synthetic sync not inserted");

   property p_drop;
      @(posedge pclk) disable iff (!presetn)
      (r.st == ST_LOCK && frame_end && !sync_det && r.miss >= r.fwd) |=> (r.st == ST_SEARCH && !frame_sync);
   endproperty
   a_drop: assert property (p_drop) else $error("window not opened after forward count");

   property p_reopen;
      @(posedge pclk) disable iff (!presetn)
      (r.st == ST_CONFIRM && frame_end && !sync_det && (r.miss + 4'h1) >= r.bwd) |=> r.st == ST_SEARCH;
   endproperty
   a_reopen: assert property (p_reopen) else $error("window not reopened after backward count");

   property p_cfg_write;
      @(posedge pclk) disable iff (!presetn)
      (apb_done && pwrite && paddr == OFS_CTRL)
         |=> (r.fwd == $past(pwdata[7:4]) && r.bwd == $past(pwdata[11:8]));
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("protection counts not written");

   property p_c1_limit;
      @(posedge pclk) disable iff (!presetn)
      (c1_res.done && !c2_res.done && c1_res.err_cnt > 3'h2) |=> correction_monitor == 4'h7;
   endproperty
   a_c1_limit: assert property (p_c1_limit) else $error("c1 beyond two errors not failed");

   property p_c1_ptr;
      @(posedge pclk) disable iff (!presetn)
      (c1_res.done && (c1_res.efm_bad || c1_res.player_bad)) |=> c1_ptr;
   endproperty
   a_c1_ptr: assert property (p_c1_ptr) else $error("c1 pointer not set from status");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (out_vld && out_c2_ptr && !r.interp) |-> out_data == $past(out_data);
   endproperty
   a_hold: assert property (p_hold) else $error("flagged sample not held");

   property p_c1_code;
      @(posedge pclk) disable iff (!presetn)
      (c1_res.done && !c2_res.done) |=> (!correction_monitor[3] && correction_monitor[3:1] != 3'h1);
   endproperty
   a_c1_code: assert property (p_c1_code) else $error("bad c1 monitor code");

   property p_c2_code;
      @(posedge pclk) disable iff (!presetn)
      c2_res.done |=> (correction_monitor[3] && correction_monitor != 4'hD);
   endproperty
   a_c2_code: assert property (p_c2_code) else $error("bad c2 monitor code");

   property p_mon_hold;
      @(posedge pclk) disable iff (!presetn)
      (!c1_res.done && !c2_res.done) |=> $stable(correction_monitor);
   endproperty
   a_mon_hold: assert property (p_mon_hold) else $error("monitor changed without a pass");

endmodule

// >>> verification/fscm_demod_model.sv
module fscm_demod_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   input wire logic [15:0] gap,
   output logic sync_det
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // sync marks
   // ------------------------------------------------------------
   // one mark per gap cycles; none while disabled, as on a scratched disc
   int cnt;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 0;
         sync_det <= 1'b0;
      end
      else
      begin
         cnt <= (en && cnt < int'(gap) - 1) ? cnt + 1 : 0;
         sync_det <= en && cnt == int'(gap) - 1;
      end
   end
endmodule

// >>> verification/fscm_bench.sv
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module fscm_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fscm_pkg::*;

   localparam int FC = 200;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, sync_det, frame_sync, frame_err, sync_locked, c1_ptr, out_vld, out_c2_ptr, irq;
   logic [3:0] correction_monitor;
   logic [15:0] out_data;
   fscm_c1_res_s c1_res = '0;
   fscm_c2_res_s c2_res = '0;
   fscm_sample_s smp_in = '0;
   logic en = 1'b0;
   logic [15:0] gap = 16'h00c8;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 32'h2ba1;
   int fs, fe;
   logic [31:0] r, v;
   logic e, p, pt, itp;
   logic [3:0] x;
   logic [15:0] last, ed;
   logic [16:0] s;
   fscm_sample_s stg, nw;

   always #12.5 pclk = ~pclk;

   fscm_top #(.FRAME_CYC(FC)) fscm_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sync_det, .c1_res, .c2_res, .smp_in, .frame_sync, .frame_err,
      .sync_locked, .c1_ptr, .correction_monitor, .out_vld, .out_data, .out_c2_ptr, .irq);

   fscm_demod_model fscm_demod_model_i (.pclk, .presetn, .en, .gap, .sync_det);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulses(input int n);
      fs = 0;
      fe = 0;
      repeat (n)
      begin
         @(posedge pclk);
         #1;
         fs += int'(frame_sync);
         fe += int'(frame_err);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      final_report();
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0000_0000);
      `CHK(r[11:0], 12'h3c0)
      apb(1'b0, 8'h10, 32'h0000_0000);
      `CHK(e, 1'b1)
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      en <= 1'b1;
      pulses(3 * FC);
      `CHK(sync_locked, 1'b1)
      gap <= 16'h00f0;
      pulses(3 * FC);
      `CHK(fe, 0)
      apb(1'b1, OFS_CTRL, 32'h0000_0c31);
      pulses(3 * FC);
      `CHK(fe > 0, 1'b1)
      gap <= 16'h00c8;
      apb(1'b1, OFS_CTRL, 32'h0000_0320);
      pulses(15 * FC);
      `CHK(sync_locked, 1'b1)
      $display("test window done");
      en <= 1'b0;
      pulses(3);
      pulses(0);
      while (sync_locked !== 1'b0)
      begin
         @(posedge pclk);
         #1;
         fs += int'(frame_sync);
         fe += int'(frame_err);
      end
      @(posedge pclk);
      #1;
      fe += int'(frame_err);
      `CHK(fs, 2)
      `CHK(fe, 3)
      `CHK(irq, 1'b1)
      apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      `CHK(r[0], 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      `CHK(r[0], 1'b0)
      en <= 1'b1;
      @(posedge sync_det);
      en <= 1'b0;
      pulses(5 * FC);
      // accepted mark plus bwd-1 inserted references before the window reopens
      `CHK(fs, 3)
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK(r[3:0], 4'h1)
      $display("test loss done");
      en <= 1'b1;
      pulses(4 * FC);
      `CHK(sync_locked, 1'b1)
      for (int i = 0; i < 32; i++)
      begin
         v = $random(seed);
         p = v[3] & v[4] | v[2:0] > 3'h2;
         pt = p | v[2:0] == 3'h2 | v[5] & v[6] | v[7] & v[8];
         @(posedge pclk);
         c1_res <= {1'b1, v[2:0], v[3] & v[4], v[5] & v[6], v[7] & v[8]};
         @(posedge pclk);
         c1_res.done <= 1'b0;
         #1;
         `CHK(correction_monitor, p ? 4'h7 : {1'b0, pt, v[1:0]})
         `CHK(c1_ptr, pt)
         p = v[12] & v[13] | v[11:9] > 3'h4;
         x = p ? (v[14] ? 4'he : 4'hf) : {1'b1, v[11:9]};
         @(posedge pclk);
         c2_res <= {1'b1, v[11:9], v[12] & v[13], v[14]};
         @(posedge pclk);
         c2_res.done <= 1'b0;
         #1;
         `CHK(correction_monitor, x)
         `CHK(c1_ptr, pt)
      end
      $display("test monitor done");
      last = 16'h0000;
      itp = 1'b0;
      for (int i = 0; i < 40; i++)
      begin
         if (i == 20)
         begin
            apb(1'b1, OFS_CTRL, 32'h0000_0322);
            itp = 1'b1;
         end
         v = $random(seed);
         nw = {1'b1, v[15:0], v[16] & v[17]};
         @(posedge pclk);
         smp_in <= nw;
         @(posedge pclk);
         smp_in.vld <= 1'b0;
         #1;
         if (i > 0)
         begin
            s = {last[15], last} + {nw.data[15], nw.data};
            ed = !stg.c2_ptr ? stg.data : (itp && !nw.c2_ptr) ? s[16:1] : last;
            `CHK({out_vld, out_c2_ptr, out_data}, {1'b1, stg.c2_ptr, ed})
            last = ed;
         end
         stg = nw;
      end
      $display("test samples done");
      final_report();
   end
endmodule
